/* scib_pkg.sv */
// package for the serial control and interrupt block: register map, fields, rates
// assumes an APB slave with 32-bit data, one register per aligned word
package scib_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;  // serial_control
	localparam logic [7:0] ADDR_STATUS = 8'h04;  // serial_control_status (flags, ro)
	localparam logic [7:0] ADDR_IEN    = 8'h08;  // event enable, status layout
	localparam logic [7:0] ADDR_ICLR   = 8'h0C;  // write-one-to-clear, status layout
	localparam logic [7:0] ADDR_EVENT  = 8'h10;  // datapath events (test/inject), wo
	localparam logic [7:0] ADDR_SYS    = 8'h14;  // cpu mask and power mode
	// control field positions
	localparam int CTRL_IRQ_EN  = 7;
	localparam int CTRL_PER_EN  = 6;
	localparam int CTRL_DIV2    = 5;
	localparam int CTRL_MASTER  = 4;
	localparam int CTRL_IDLE    = 3;
	localparam int CTRL_PHASE   = 2;
	localparam int CTRL_RATE_HI = 1;
	localparam int CTRL_RATE_LO = 0;
	localparam logic [3:0] CTRL_UPPER_RST = 4'h0;  // upper nibble after reset
	localparam logic [3:0] CTRL_LOWER_RST = 4'h0;  // lower nibble: undefined, zero here
	// enable register: writable bits, also its reset value (all three events on)
	localparam logic [7:0] IEN_BITS = 8'hB0;
	// system register after reset: cpu interrupt masked, running
	localparam logic [2:0] SYS_RST  = 3'h1;
	// status field positions
	localparam int ST_XFER  = 7;
	localparam int ST_OVR   = 5;
	localparam int ST_MODE_FAULT_FLAG  = 4;
	// event register bits
	localparam int EV_DONE  = 0;  // byte finished
	localparam int EV_READY = 1;  // received byte ready to move
	// system register bits
	localparam int SYS_MASK = 0;  // cpu interrupt mask (1 = masked)
	localparam int SYS_WAIT = 1;  // cpu in wait mode
	localparam int SYS_HALT = 2;  // cpu in halt mode
	// sck half periods in cpu clocks, by {div2, rate}
	localparam logic [6:0] HALF_4   = 7'h02;
	localparam logic [6:0] HALF_8   = 7'h04;
	localparam logic [6:0] HALF_16  = 7'h08;
	localparam logic [6:0] HALF_32  = 7'h10;
	localparam logic [6:0] HALF_64  = 7'h20;
	localparam logic [6:0] HALF_128 = 7'h40;
	localparam logic [31:0] ZERO32  = 32'h0000_0000;
endpackage : scib_pkg

/* scib_divider.sv */
// sck generator: one-cycle enable pulse every half period, level follows polarity
// assumes the caller holds run low outside master operation
`timescale 1ns/10ps
module scib_divider
	import scib_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// control
	input  wire logic       run_i,     // count while high
	input  wire logic       idle_i,    // idle level
	input  wire logic [2:0] code_i,    // {div2, rate1, rate0}
	// outputs
	output logic            tick_o,    // one-cycle pulse at each sck edge
	output logic            sck_o      // clock level
);
	logic [6:0] cnt_reg, cnt_next;    // half period counter
	logic       sck_reg, sck_next;    // clock level
	logic [6:0] half;                 // selected half period

	// decode the rate code
	always_comb begin
		unique case (code_i)
			3'h4:    half = HALF_4;
			3'h0:    half = HALF_8;
			3'h1:    half = HALF_16;
			3'h6:    half = HALF_32;
			3'h2:    half = HALF_64;
			3'h3:    half = HALF_128;
			default: half = HALF_128;  // undocumented codes run slowest
		endcase
	end

	// count and toggle
	always_comb begin
		cnt_next = cnt_reg;
		sck_next = sck_reg;
		tick_o   = 1'b0;
		if (!run_i) begin
			cnt_next = 7'h00;
			sck_next = idle_i;  // idle level while stopped
		end else if (cnt_reg >= half - 7'h01) begin  // a faster rate never waits for a wrap
			cnt_next = 7'h00;
			sck_next = ~sck_reg;
			tick_o   = 1'b1;
		end else begin
			cnt_next = cnt_reg + 7'h01;
		end
	end

	// register
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cnt_reg <= 7'h00;
			sck_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			sck_reg <= sck_next;
		end
	end

	assign sck_o = sck_reg;
endmodule : scib_divider

/* scib_top.sv */
// control register, event flags, interrupt and wake-up logic of the serial block
// assumes an APB master on the cpu side and the shift datapath reporting events
`timescale 1ns/10ps

// How it works
// - three events share one masked interrupt
// - any enabled event wakes wait; halt only transfer
// - fault and overrun never wake halt
// - bit 7 enables interrupt on any flag
// - bit 6 selects alternate pins, reset clears
// - master with select low clears enable, master
// - bit 4 master drives sck, swaps data
// - bit 3 sets sck idle level
// - bit 2 selects first capture edge
// - both ends use same polarity, phase
// - master sck divided by three-bit code
// - bit 5 divide-by-two, cleared on reset
// - rate bits ignored in slave role
// - reset zeroes upper control nibble
// - transfer flag set per completed byte
// - overrun when byte ready, flag set
// - fault cleared by status read, control write
module scib_top (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// datapath events
	input  wire logic        byte_done_i,   // pulse: a byte transfer finished
	input  wire logic        rx_ready_i,    // pulse: received byte ready to move
	input  wire logic        ss_b_i,        // slave select pin, active low
	// pin control
	output logic             pins_alt_o,    // serial pins on alternate function
	output logic             sck_oe_o,      // sck driven (master)
	output logic             sck_o,         // sck level
	output logic             mosi_oe_o,     // mosi driven (master)
	output logic             miso_oe_o,     // miso driven (slave)
	output logic             clock_idle_level_o,
	output logic             clock_capture_phase_o,
	output logic             sck_tick_o,    // pulse at each master sck edge
	// cpu side
	output logic             irq_o,         // shared interrupt request
	output logic             wake_wait_o,   // wake from wait
	output logic             wake_halt_o    // wake from halt
);
	import scib_pkg::*;

	logic [7:0] ctrl_reg, ctrl_next;        // serial_control
	logic       xfer_reg, xfer_next;        // transfer_complete_flag
	logic       ovr_reg, ovr_next;          // overrun_flag
	logic       mode_fault_flag_reg, mode_fault_flag_next;        // mode_fault_flag
	logic       mode_fault_flag_armed_reg, mode_fault_flag_armed_next; // status read seen with fault set
	logic [7:0] ien_reg, ien_next;          // enable register, status layout
	logic [2:0] sys_reg, sys_next;          // cpu mask, wait, halt
	logic [31:0] rdata_reg, rdata_next;     // read data
	logic       ready_reg, ready_next;      // apb ready
	logic       err_reg, err_next;          // apb error
	logic       irq_reg;                    // shared interrupt request
	logic       irq_next;                   // next interrupt request
	logic       ww_reg;                     // wake from wait
	logic       ww_next;                    // next wake from wait
	logic       wh_reg;                     // wake from halt
	logic       wh_next;                    // next wake from halt
	logic       alt_reg;                    // pins on alternate function
	logic       sck_oe_reg;                 // sck driven
	logic       mosi_reg;                   // mosi driven
	logic       miso_reg;                   // miso driven
	logic       idle_reg;                   // copy of the idle level bit
	logic       phase_reg;                  // copy of the capture phase bit
	logic       sck_q_reg, tick_reg;        // registered clock outputs
	logic       setup, wr, rd, mapped;      // bus decode
	logic [7:0] status;                     // status image
	logic       fault;                      // master sees select low
	logic       div_tick, div_sck;          // divider outputs
	logic       ev_done, ev_ready;          // merged events

	// bus decode: answer in the first access cycle
	assign setup  = psel_i & ~penable_i;
	assign wr     = psel_i & penable_i & ready_reg & pwrite_i;
	assign rd     = psel_i & penable_i & ready_reg & ~pwrite_i;
	assign mapped = (paddr_i == ADDR_CTRL) | (paddr_i == ADDR_STATUS) |
		(paddr_i == ADDR_IEN) | (paddr_i == ADDR_ICLR) |
		(paddr_i == ADDR_EVENT) | (paddr_i == ADDR_SYS);

	assign status = {xfer_reg, 1'b0, ovr_reg, mode_fault_flag_reg, 4'h0};
	assign fault  = ctrl_reg[CTRL_MASTER] & ~ss_b_i;
	assign ev_done  = byte_done_i | (wr & paddr_i == ADDR_EVENT & pstrb_i[0] &
		pwdata_i[EV_DONE]);
	assign ev_ready = rx_ready_i | (wr & paddr_i == ADDR_EVENT & pstrb_i[0] &
		pwdata_i[EV_READY]);

	// sck divider, runs only in master role with pins enabled
	scib_divider u_div (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.run_i   (ctrl_reg[CTRL_MASTER] & ctrl_reg[CTRL_PER_EN]),
		.idle_i  (ctrl_reg[CTRL_IDLE]),
		.code_i  ({ctrl_reg[CTRL_DIV2], ctrl_reg[CTRL_RATE_HI:CTRL_RATE_LO]}),
		.tick_o  (div_tick),
		.sck_o   (div_sck)
	);

	// bus answer
	always_comb begin
		ready_next = setup;
		err_next   = 1'b0;
		rdata_next = rdata_reg;
		if (setup) begin
			err_next = ~mapped;  // unmapped address answers with an error
			if (!pwrite_i) begin
				unique case (paddr_i)
					ADDR_CTRL:   rdata_next = {24'h000000, ctrl_reg};
					ADDR_STATUS: rdata_next = {24'h000000, status};
					ADDR_IEN:    rdata_next = {24'h000000, ien_reg};
					ADDR_SYS:    rdata_next = {29'h00000000, sys_reg};
					default:     rdata_next = ZERO32;
				endcase
			end
		end
	end

	// control register and cpu state
	always_comb begin
		ctrl_next = ctrl_reg;
		ien_next  = ien_reg;
		sys_next  = sys_reg;
		if (wr & pstrb_i[0]) begin
			if (paddr_i == ADDR_CTRL) begin
				ctrl_next = pwdata_i[7:0];
				// while faulted, enable and master may only be set in the clearing write
				if (mode_fault_flag_reg & ~mode_fault_flag_armed_reg) begin
					ctrl_next[CTRL_PER_EN] = ctrl_reg[CTRL_PER_EN];
					ctrl_next[CTRL_MASTER] = ctrl_reg[CTRL_MASTER];
				end
			end
			if (paddr_i == ADDR_IEN)
				ien_next = pwdata_i[7:0] & IEN_BITS;
			if (paddr_i == ADDR_SYS)
				sys_next = pwdata_i[2:0];
		end
		// fault pulls the block off the pins and into slave role
		if (fault) begin
			ctrl_next[CTRL_PER_EN] = 1'b0;
			ctrl_next[CTRL_MASTER] = 1'b0;
		end
	end

	// event flags: hardware set wins over clearing
	always_comb begin
		xfer_next       = xfer_reg;
		ovr_next        = ovr_reg;
		mode_fault_flag_next       = mode_fault_flag_reg;
		mode_fault_flag_armed_next = mode_fault_flag_armed_reg;
		// status read clears overrun, arms the fault clear
		if (rd & paddr_i == ADDR_STATUS) begin
			ovr_next        = 1'b0;
			mode_fault_flag_armed_next = mode_fault_flag_reg;
		end
		if (wr & pstrb_i[0] & paddr_i == ADDR_CTRL & mode_fault_flag_armed_reg) begin
			mode_fault_flag_next       = 1'b0;
			mode_fault_flag_armed_next = 1'b0;
		end
		if (wr & pstrb_i[0] & paddr_i == ADDR_ICLR) begin
			xfer_next = xfer_reg & ~pwdata_i[ST_XFER];
			ovr_next  = ovr_next & ~pwdata_i[ST_OVR];
		end
		if (ev_ready & xfer_reg)
			ovr_next = 1'b1;
		if (ev_done)
			xfer_next = 1'b1;
		if (fault)
			mode_fault_flag_next = 1'b1;
	end

	// interrupt and wake-up
	always_comb begin
		// each enable bit must also be on, plus the common enable
		irq_next = ctrl_reg[CTRL_IRQ_EN] & |(status & ien_reg) &
			~sys_reg[SYS_MASK];
		ww_next  = sys_reg[SYS_WAIT] & ctrl_reg[CTRL_IRQ_EN] &
			|(status & ien_reg);
		wh_next  = sys_reg[SYS_HALT] & ctrl_reg[CTRL_IRQ_EN] &
			xfer_reg & ien_reg[ST_XFER];
	end

	// registers
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ctrl_reg       <= {CTRL_UPPER_RST, CTRL_LOWER_RST};
			xfer_reg       <= 1'b0;
			ovr_reg        <= 1'b0;
			mode_fault_flag_reg       <= 1'b0;
			mode_fault_flag_armed_reg <= 1'b0;
			ien_reg        <= IEN_BITS;
			sys_reg        <= SYS_RST;
			rdata_reg      <= ZERO32;
			ready_reg      <= 1'b0;
			err_reg        <= 1'b0;
			irq_reg        <= 1'b0;
			ww_reg         <= 1'b0;
			wh_reg         <= 1'b0;
			alt_reg        <= 1'b0;
			sck_oe_reg     <= 1'b0;
			mosi_reg       <= 1'b0;
			miso_reg       <= 1'b0;
			idle_reg       <= 1'b0;
			phase_reg      <= 1'b0;
			sck_q_reg      <= 1'b0;
			tick_reg       <= 1'b0;
		end else begin
			ctrl_reg       <= ctrl_next;
			xfer_reg       <= xfer_next;
			ovr_reg        <= ovr_next;
			mode_fault_flag_reg       <= mode_fault_flag_next;
			mode_fault_flag_armed_reg <= mode_fault_flag_armed_next;
			ien_reg        <= ien_next;
			sys_reg        <= sys_next;
			rdata_reg      <= rdata_next;
			ready_reg      <= ready_next;
			err_reg        <= err_next;
			irq_reg        <= irq_next;
			ww_reg         <= ww_next;
			wh_reg         <= wh_next;
			alt_reg        <= ctrl_reg[CTRL_PER_EN];
			sck_oe_reg     <= ctrl_reg[CTRL_PER_EN] & ctrl_reg[CTRL_MASTER];
			mosi_reg       <= ctrl_reg[CTRL_PER_EN] & ctrl_reg[CTRL_MASTER];
			miso_reg       <= ctrl_reg[CTRL_PER_EN] & ~ctrl_reg[CTRL_MASTER];
			idle_reg       <= ctrl_reg[CTRL_IDLE];
			phase_reg      <= ctrl_reg[CTRL_PHASE];
			sck_q_reg      <= div_sck;
			tick_reg       <= div_tick;
		end
	end

	// outputs
	assign prdata_o              = rdata_reg;
	assign pready_o              = ready_reg;
	assign pslverr_o             = err_reg;
	assign pins_alt_o            = alt_reg;
	assign sck_oe_o              = sck_oe_reg;
	assign sck_o                 = sck_q_reg;
	assign mosi_oe_o             = mosi_reg;
	assign miso_oe_o             = miso_reg;
	assign clock_idle_level_o    = idle_reg;
	assign clock_capture_phase_o = phase_reg;
	assign sck_tick_o            = tick_reg;
	assign irq_o                 = irq_reg;
	assign wake_wait_o           = ww_reg;
	assign wake_halt_o           = wh_reg;
endmodule : scib_top

/* scib_top_assertions.sv */
// checker for the serial control block: bus answer, pin roles, irq gating
// assumes it is bound to scib_top and sees only its ports
`timescale 1ns/10ps
module scib_top_assertions
	import scib_pkg::*;
(
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	// apb
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0]  pstrb_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	// link and cpu side
	input wire logic        ss_b_i,
	input wire logic        sck_oe_o,
	input wire logic        sck_o,
	input wire logic        mosi_oe_o,
	input wire logic        miso_oe_o,
	input wire logic        clock_idle_level_o,
	input wire logic        sck_tick_o,
	input wire logic        irq_o,
	input wire logic        wake_wait_o,
	input wire logic        wake_halt_o
);
	logic ie_reg;   // shadow of the irq enable bit
	logic ie_next;  // next shadow value
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// follow accepted control writes; hardware never clears bit 7
	always_comb begin
		ie_next = ie_reg;
		if (psel_i && penable_i && pwrite_i && pready_o &&
			paddr_i == ADDR_CTRL && pstrb_i[0]) begin
			ie_next = pwdata_i[CTRL_IRQ_EN];
		end
	end
	// register the shadow
	always_ff @(posedge clk_i) begin
		ie_reg <= rst_b_i ? ie_next : 1'b0;
	end
	a_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	a_err_unmapped: assert property (pready_o && paddr_i > ADDR_SYS |-> pslverr_o)
		else $error("unmapped access not flagged");
	a_irq_needs_en: assert property (irq_o |-> $past(ie_reg))
		else $error("irq without enable");
	a_halt_needs_en: assert property (wake_halt_o |-> $past(ie_reg))
		else $error("halt wake without enable");
	a_wait_needs_en: assert property (wake_wait_o |-> $past(ie_reg))
		else $error("wait wake without enable");
	a_oe_roles: assert property (!(mosi_oe_o && miso_oe_o) && sck_oe_o == mosi_oe_o)
		else $error("pin directions inconsistent");
	a_fault_drops: assert property (sck_oe_o && !ss_b_i |-> ##[1:3] !sck_oe_o)
		else $error("master kept after select low");
	a_quiet_tick: assert property (!sck_oe_o [*3] |-> !sck_tick_o)
		else $error("sck edge while not master");
	a_idle_level: assert property (
		(!sck_oe_o && $stable(clock_idle_level_o)) [*3] |-> sck_o == clock_idle_level_o)
		else $error("sck not at idle level");
	a_tick_gap: assert property (sck_tick_o |=> !sck_tick_o)
		else $error("sck edges too close");
endmodule : scib_top_assertions

bind scib_top scib_top_assertions u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.pstrb_i(pstrb_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .ss_b_i(ss_b_i),
	.sck_oe_o(sck_oe_o), .sck_o(sck_o), .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o),
	.clock_idle_level_o(clock_idle_level_o), .sck_tick_o(sck_tick_o), .irq_o(irq_o),
	.wake_wait_o(wake_wait_o), .wake_halt_o(wake_halt_o));

/* scib_far_end.sv */
// far-end model: spi partner that counts link clock edges into bytes
// assumes sck edges arrive as one-cycle ticks while sck is driven
`timescale 1ns/10ps
module scib_far_end (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// link side
	input  wire logic sck_oe_i,    // master drives sck
	input  wire logic sck_tick_i,  // one sck edge
	input  wire logic select_i,    // bench pulls select low
	output logic      ss_b_o,      // select, pulled high otherwise
	output logic      done_o,      // byte finished pulse
	output logic      ready_o      // received byte ready pulse
);
	logic [3:0] edge_reg;   // sck edges seen in this byte
	logic [3:0] edge_next;  // next edge count
	logic       last;       // sixteenth edge of a byte
	// two edges a bit whatever the shared polarity and phase
	always_comb begin
		last = sck_oe_i && sck_tick_i && edge_reg == 4'hF;
		edge_next = sck_oe_i ? edge_reg + {3'h0, sck_tick_i} : 4'h0;
	end
	// register count and byte pulses
	always_ff @(posedge clk_i) begin
		edge_reg <= rst_b_i ? edge_next : 4'h0;
		done_o <= rst_b_i && last;
		ready_o <= rst_b_i && last;
	end
	assign ss_b_o = !select_i;  // pull-up holds select high
endmodule : scib_far_end

/* tb_top.sv */
// self-checking bench for the serial control block over apb
// assumes scib_top, the far-end model and the checker bind are compiled first
`timescale 1ns/10ps
module tb_top;
	import scib_pkg::*;
	logic        clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd_data;
	logic        rd_err, byte_done_i, rx_ready_i, ss_b_i, sel, pins_alt_o, sck_oe_o, sck_o;
	logic        mosi_oe_o, miso_oe_o, idle_o, phase_o, sck_tick_o, irq_o, wake_w, wake_h;
	int          failures, tests_run, n, k;
	logic [7:0]  rc [6] = '{8'h20, 8'h00, 8'h01, 8'h22, 8'h02, 8'h03};  // rate codes
	int          dv [6] = '{4, 8, 16, 32, 64, 128};                     // divisors
	// device under test
	scib_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.byte_done_i(byte_done_i), .rx_ready_i(rx_ready_i), .ss_b_i(ss_b_i),
		.pins_alt_o(pins_alt_o), .sck_oe_o(sck_oe_o), .sck_o(sck_o), .mosi_oe_o(mosi_oe_o),
		.miso_oe_o(miso_oe_o), .clock_idle_level_o(idle_o), .clock_capture_phase_o(phase_o),
		.sck_tick_o(sck_tick_o), .irq_o(irq_o), .wake_wait_o(wake_w), .wake_halt_o(wake_h));
	// far side of the link
	scib_far_end u_far (.clk_i(clk_i), .rst_b_i(rst_b_i), .sck_oe_i(sck_oe_o),
		.sck_tick_i(sck_tick_o), .select_i(sel), .ss_b_o(ss_b_i), .done_o(byte_done_i),
		.ready_o(rx_ready_i));
	// 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// compare a word
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// compare one pin
	task automatic chb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chb
	// one apb transfer: setup, then access until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// only the watchdog ends a wait for ready
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd_data = prdata_o;
		rd_err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	// write a byte register
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask : wr
	// read a register and compare
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, ZERO32);
		chk(rd_data, {24'h0, exp});
	endtask : rdc
	// cycles until the next sck edge, 300 if none
	task automatic tick_gap(output int c);
		c = 0;
		do begin
			@(posedge clk_i);
			c++;
		end while (sck_tick_o !== 1'b1 && c < 300);
	endtask : tick_gap
	// let some edges pass
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_i);
	endtask : cyc
	// print counts and verdict, then stop
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// watchdog against a hang
	initial begin
		#300000;
		failures++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		failures = 0;
		tests_run = 0;
		{rst_b_i, psel_i, penable_i, pwrite_i, sel} = 5'h00;
		paddr_i = 8'h00;
		pwdata_i = ZERO32;
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rdc(ADDR_CTRL, 8'h00);
		rdc(ADDR_IEN, 8'hB0);
		rdc(ADDR_SYS, 8'h01);
		apb(1'b0, 8'h40, ZERO32);
		chb(rd_err, 1'b1);
		foreach (rc[i]) begin
			wr(ADDR_CTRL, 8'h50 | rc[i]);
			tick_gap(n);
			tick_gap(n);
			chk(n * 2, dv[i]);
		end
		chb(pins_alt_o, 1'b1);
		chb(mosi_oe_o & sck_oe_o & ~miso_oe_o, 1'b1);
		wr(ADDR_CTRL, 8'h63);
		tick_gap(n);
		chk(n, 300);
		chb(miso_oe_o & ~sck_oe_o, 1'b1);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_CTRL, 8'h0C);
		cyc(3);
		chb(idle_o & sck_o, 1'b1);
		chb(phase_o, 1'b1);
		chb(pins_alt_o, 1'b0);
		apb(1'b0, ADDR_STATUS, ZERO32);
		wr(ADDR_ICLR, 8'hA0);
		rdc(ADDR_STATUS, 8'h00);
		wr(ADDR_SYS, 8'h00);
		wr(ADDR_CTRL, 8'hF0);
		n = 0;
		k = 0;
		while (k < 2 && n < 500) begin
			@(posedge clk_i);
			n++;
			if (byte_done_i === 1'b1) k++;
		end
		chk(k, 2);
		wr(ADDR_CTRL, 8'h80);
		chb(irq_o, 1'b1);
		rdc(ADDR_STATUS, 8'hA0);
		rdc(ADDR_STATUS, 8'h80);
		wr(ADDR_ICLR, 8'h80);
		cyc(3);
		chb(irq_o, 1'b0);
		wr(ADDR_SYS, 8'h01);
		wr(ADDR_EVENT, 8'h01);
		cyc(3);
		chb(irq_o, 1'b0);
		wr(ADDR_SYS, 8'h00);
		cyc(3);
		chb(irq_o, 1'b1);
		wr(ADDR_CTRL, 8'h00);
		cyc(3);
		chb(irq_o, 1'b0);
		wr(ADDR_ICLR, 8'h80);
		wr(ADDR_SYS, 8'h04);
		wr(ADDR_CTRL, 8'hD0);
		sel <= 1'b1;
		cyc(4);
		rdc(ADDR_CTRL, 8'h80);
		chb(irq_o, 1'b1);
		chb(wake_h, 1'b0);
		wr(ADDR_SYS, 8'h02);
		cyc(3);
		chb(wake_w, 1'b1);
		sel <= 1'b0;
		wr(ADDR_CTRL, 8'hD0);
		rdc(ADDR_CTRL, 8'h80);
		rdc(ADDR_STATUS, 8'h10);
		wr(ADDR_CTRL, 8'h80);
		rdc(ADDR_STATUS, 8'h00);
		wr(ADDR_SYS, 8'h04);
		wr(ADDR_EVENT, 8'h01);
		cyc(3);
		chb(wake_h, 1'b1);
		tally_and_finish();
	end
endmodule : tb_top
